// file: core/css_bit_cell.sv
`timescale 1ns/10ps
// one configurable storage bit: d, t or jk behaviour
module css_bit_cell #(
   parameter css_pkg::css_ff_type FF_KIND = css_pkg::CSS_FF_D
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic d_in,
   input  wire logic j_in,
   input  wire logic k_in,
   output logic      q
);
   typedef struct packed {
      logic q;
   } css_cell_type;

   css_cell_type st_reg;
   css_cell_type st_next;

   always_comb begin
      st_next = st_reg;
      case (FF_KIND)
         css_pkg::CSS_FF_D:  st_next.q = d_in;
         css_pkg::CSS_FF_T:  st_next.q = st_reg.q ^ d_in;
         css_pkg::CSS_FF_JK: st_next.q = (j_in & ~st_reg.q) | (~k_in & st_reg.q);
         default:            st_next.q = d_in;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign q = st_reg.q;
endmodule // css_bit_cell

// file: core/css_pkg.sv
package css_pkg;
   // ---------------------------------------------------------------
   // limits and reset values
   // ---------------------------------------------------------------
   localparam int MAX_STATE_BITS = 24;
   localparam int DEF_STATE_BITS = 4;
   localparam int DEF_CONDS      = 4;
   localparam int DEF_INPUTS     = 4;
   localparam int DEF_OUTS       = 4;
   localparam int STATE_RESET    = 0;

   // ---------------------------------------------------------------
   // flip-flop kinds
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      CSS_FF_D,
      CSS_FF_T,
      CSS_FF_JK
   } css_ff_type;
endpackage

// file: core/css_sequencer.sv
`timescale 1ns/10ps
// generic case/else state sequencer with transition, mealy and moore outputs.
// per-state tables are flattened parameter vectors indexed by state number.
module css_sequencer #(
   parameter int                  SW         = css_pkg::DEF_STATE_BITS,
   parameter int                  NC         = css_pkg::DEF_CONDS,
   parameter int                  NI         = css_pkg::DEF_INPUTS,
   parameter int                  NO         = css_pkg::DEF_OUTS,
   parameter css_pkg::css_ff_type STATE_FF   = css_pkg::CSS_FF_D,
   parameter bit                  NEG_EDGE   = 1'b0,
   // per state s, condition c: input mask and match value on NI inputs
   parameter logic [(2**SW)*NC*NI-1:0] COND_MASK  = '0,
   parameter logic [(2**SW)*NC*NI-1:0] COND_VAL   = '0,
   parameter logic [(2**SW)*NC-1:0]    COND_EN    = '0,
   parameter logic [(2**SW)*NC*SW-1:0] COND_TGT   = '0,
   // per state: default target enable and value
   parameter logic [(2**SW)-1:0]       DEF_EN     = '0,
   parameter logic [(2**SW)*SW-1:0]    DEF_TGT    = '0,
   // per state, condition: transition output enable and d value; per output: toggle mode
   parameter logic [(2**SW)*NC*NO-1:0] TR_EN      = '0,
   parameter logic [(2**SW)*NC*NO-1:0] TR_VAL     = '0,
   parameter logic [NO-1:0]            TR_TOGGLE  = '0,
   // per state: moore output pattern, mealy input-select mask
   parameter logic [(2**SW)*NO-1:0]    MOORE_PAT  = '0,
   parameter logic [(2**SW)*NO-1:0]    MEALY_SEL  = '0
) (
   input  wire logic          REF_CLK,
   input  wire logic          RESETN,
   input  wire logic [NI-1:0] IN_PINS,
   output logic      [SW-1:0] STATE,
   output logic      [NO-1:0] TRANS_OUT,
   output logic      [NO-1:0] MEALY_REG,
   output logic      [NO-1:0] MOORE_REG,
   output logic      [NO-1:0] MEALY_COM,
   output logic      [NO-1:0] MOORE_COM
);
   if (SW > css_pkg::MAX_STATE_BITS || SW < 1) begin : g_bad_width
      $error("state width out of range");
   end

   // ---------------------------------------------------------------
   // table layout
   // ---------------------------------------------------------------
   // entry k = state*NC + cond; each entry is a slice of the flat vector
   // cond slices are NI wide, target slices SW, output slices NO
   // state tables grow as 2**SW, so wide machines cost elaboration time
   // overlapping conditions are a table fault; lowest index wins silently
   // all 2**SW codes decode; there is no illegal-state trap
   // unused codes with empty tables fall to zero (d) or hold (t, jk)
   // mealy reads the low NO synchronised pins, so NI must be at least NO

   // ---------------------------------------------------------------
   // input synchroniser and registered outputs
   // ---------------------------------------------------------------
   // pins are asynchronous; only sync2 feeds a decision
   typedef struct packed {
      logic [NI-1:0] sync1;
      logic [NI-1:0] sync2;
      logic [NO-1:0] trans;
      logic [NO-1:0] mealy;
      logic [NO-1:0] moore;
      logic [SW-1:0] state_cp;
   } css_main_type;

   css_main_type m_reg;
   css_main_type m_next;

   logic          clk_i;
   logic [SW-1:0] state_q;
   logic [SW-1:0] d_bits;
   logic [SW-1:0] j_bits;
   logic [SW-1:0] k_bits;
   logic [SW-1:0] tgt;
   logic          hit;
   logic [NC-1:0] hit_vec;
   int            hit_idx;

   // ---------------------------------------------------------------
   // active edge
   // ---------------------------------------------------------------
   // constant select, so the inverted clock cannot glitch
   // selectable active edge
   assign clk_i = NEG_EDGE ? ~REF_CLK : REF_CLK;

   // ---------------------------------------------------------------
   // next-state selection
   // ---------------------------------------------------------------
   always_comb begin
      logic [NI-1:0] mk;
      logic [NI-1:0] vl;
      mk      = '0;
      vl      = '0;
      hit_vec = '0;
      for (int c = 0; c < NC; c++) begin
         mk = COND_MASK[(int'(state_q)*NC+c)*NI +: NI];
         vl = COND_VAL[(int'(state_q)*NC+c)*NI +: NI];
         hit_vec[c] = COND_EN[int'(state_q)*NC+c] & (((m_reg.sync2 ^ vl) & mk) == '0);
      end
   end

   always_comb begin
      hit     = 1'b0;
      hit_idx = 0;
      // hit_idx means nothing while hit is clear
      // first match wins
      for (int c = NC-1; c >= 0; c--) begin
         if (hit_vec[c]) begin
            hit     = 1'b1;
            hit_idx = c;
         end
      end
   end

   always_comb begin
      tgt    = '0;
      d_bits = '0;
      j_bits = '0;
      k_bits = '0;
      if (hit) begin
         tgt = COND_TGT[(int'(state_q)*NC+hit_idx)*SW +: SW];
      end else if (DEF_EN[int'(state_q)]) begin
         tgt = DEF_TGT[int'(state_q)*SW +: SW];
      end else if (STATE_FF == css_pkg::CSS_FF_D) begin
         tgt = SW'(css_pkg::STATE_RESET);
      end else begin
         tgt = state_q;
      end
      case (STATE_FF)
         css_pkg::CSS_FF_D:  d_bits = tgt;
         css_pkg::CSS_FF_T:  d_bits = tgt ^ state_q;
         css_pkg::CSS_FF_JK: begin
            j_bits = tgt;
            k_bits = ~tgt;
         end
         default:            d_bits = tgt;
      endcase
   end

   // ---------------------------------------------------------------
   // state bits; index 0 is the first allocated bit
   // ---------------------------------------------------------------
   // state flip-flop bank
   for (genvar b = 0; b < SW; b++) begin : g_state
      css_bit_cell #(
         .FF_KIND (STATE_FF)
      ) u_cell (
         .clk     (clk_i),
         .rst_n   (RESETN),
         .d_in    (d_bits[b]),
         .j_in    (j_bits[b]),
         .k_in    (k_bits[b]),
         .q       (state_q[b])
      );
   end

   // ---------------------------------------------------------------
   // output computation
   // ---------------------------------------------------------------
   always_comb begin
      logic [NO-1:0] en;
      logic [NO-1:0] vl;
      en           = '0;
      vl           = '0;
      m_next       = m_reg;
      m_next.sync1 = IN_PINS;
      m_next.sync2 = m_reg.sync1;
      m_next.state_cp = tgt;
      if (hit) begin
         en = TR_EN[(int'(state_q)*NC+hit_idx)*NO +: NO];
         vl = TR_VAL[(int'(state_q)*NC+hit_idx)*NO +: NO];
      end
      for (int o = 0; o < NO; o++) begin
         if (en[o]) begin
            // value bit doubles as toggle enable in toggle mode
            // toggle on transition
            if (TR_TOGGLE[o]) begin
               m_next.trans[o] = m_reg.trans[o] ^ vl[o];
            end else begin
               m_next.trans[o] = vl[o];
            end
         end
      end
      m_next.mealy = MEALY_SEL[int'(state_q)*NO +: NO] & m_reg.sync2[0 +: NO];
      m_next.moore = MOORE_PAT[int'(tgt)*NO +: NO];
   end

   // ---------------------------------------------------------------
   // output and synchroniser registers
   // ---------------------------------------------------------------
   // registers cleared
   always_ff @(posedge clk_i) begin
      if (!RESETN) begin
         m_reg <= '0;
      end else begin
         m_reg <= m_next;
      end
   end

   // registered copy so the state port comes straight from a flip-flop
   assign STATE     = m_reg.state_cp;
   assign TRANS_OUT = m_reg.trans;
   assign MEALY_REG = m_reg.mealy;
   assign MOORE_REG = m_reg.moore;

   // ---------------------------------------------------------------
   // combinational outputs
   // ---------------------------------------------------------------
   // combinational forms; the only unregistered outputs, kept by design
   // combinational outputs
   always_comb begin
      MEALY_COM = MEALY_SEL[int'(state_q)*NO +: NO] & m_reg.sync2[0 +: NO];
      MOORE_COM = MOORE_PAT[int'(state_q)*NO +: NO];
   end
endmodule // css_sequencer

// file: sim/css_seq_properties.sv
`timescale 1ns/10ps
module css_seq_properties #(
   parameter int                    SW   = 2,
   parameter int                    NI   = 2,
   parameter int                    NO   = 2,
   parameter logic [(2**SW)*NO-1:0] MPAT = '0,
   parameter logic [(2**SW)*NO-1:0] MSEL = '0
) (
   input wire logic          REF_CLK,
   input wire logic          RESETN,
   input wire logic [NI-1:0] IN_PINS,
   input wire logic [SW-1:0] STATE,
   input wire logic [NO-1:0] TRANS_OUT,
   input wire logic [NO-1:0] MEALY_REG,
   input wire logic [NO-1:0] MOORE_REG,
   input wire logic [NO-1:0] MEALY_COM,
   input wire logic [NO-1:0] MOORE_COM
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESETN);
   // ------------------------------------------
   // output relations; out0/out1 ones fit the bench tables only
   // ------------------------------------------
   moore_com_a: assert property (MOORE_COM == MPAT[STATE*NO+:NO])
      else $error("moore comb output wrong");
   moore_reg_a: assert property (MOORE_REG == MPAT[STATE*NO+:NO])
      else $error("moore reg output wrong");
   // inputs pass two sync flops, so look two edges back
   mealy_com_a: assert property ($past(RESETN) && $past(RESETN, 2) |->
      MEALY_COM == (MSEL[STATE*NO+:NO] & $past(IN_PINS[NO-1:0], 2)))
      else $error("mealy comb output wrong");
   mealy_reg_a: assert property ($past(RESETN) |-> MEALY_REG == $past(MEALY_COM))
      else $error("mealy reg output wrong");
   reset_clear_a: assert property ($rose(RESETN) |->
      STATE == '0 && TRANS_OUT == '0 && MEALY_REG == '0)
      else $error("reset left state or outputs set");
   untaken_hold_a: assert property ($past(RESETN) && $stable(STATE) |-> $stable(TRANS_OUT))
      else $error("transition output moved without transition");
   toggle_out_a: assert property ($past(RESETN) |->
      $changed(TRANS_OUT[0]) == ($past(STATE) == 0 && STATE == 1))
      else $error("toggle output wrong");
   set_out_a: assert property ($past(RESETN) && $rose(TRANS_OUT[1]) |->
      $past(STATE) == 1 && STATE == 3)
      else $error("out1 set off its transition");
   clr_out_a: assert property ($past(RESETN) && $fell(TRANS_OUT[1]) |->
      $past(STATE) == 3 && STATE == 0)
      else $error("out1 cleared off its transition");
   cover property (STATE == 3);
   cover property ($changed(TRANS_OUT[0]));
   cover property (MEALY_COM != '0);
endmodule // css_seq_properties

bind css_sequencer css_seq_properties #(
   .SW(SW), .NI(NI), .NO(NO), .MPAT(MOORE_PAT), .MSEL(MEALY_SEL)
) css_seq_properties_inst (
   .REF_CLK(REF_CLK), .RESETN(RESETN), .IN_PINS(IN_PINS), .STATE(STATE),
   .TRANS_OUT(TRANS_OUT), .MEALY_REG(MEALY_REG), .MOORE_REG(MOORE_REG),
   .MEALY_COM(MEALY_COM), .MOORE_COM(MOORE_COM)
);

// file: sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   logic            ref_clk   = 1'b0;
   logic            resetn    = 1'b0;
   logic [1:0]      in_pins   = 2'h0;
   wire  [1:0][1:0] st;
   wire  [1:0][1:0] tr;
   int              err_total = 0;
   int              n_checks  = 0;
   // out0 toggles on 0 to 1; out1 sets on 1 to 3 and clears on 3 to 0
   localparam int          TB_W      = 2;
   localparam logic [15:0] TB_MASK   = 16'h337f;
   localparam logic [15:0] TB_VAL    = 16'h0379;
   localparam logic [7:0]  TB_EN     = 8'h5f;
   localparam logic [15:0] TB_TGT    = 16'h03b9;
   localparam logic [3:0]  TB_DEF_EN = 4'h4;
   localparam logic [7:0]  TB_DEF    = 8'h10;
   localparam logic [15:0] TB_TR_EN  = 16'h2021;
   localparam logic [15:0] TB_TR_VAL = 16'h0021;
   localparam logic [1:0]  TB_TOGGLE = 2'h1;
   localparam logic [7:0]  TB_MOORE  = 8'he4;
   localparam logic [7:0]  TB_MEALY  = 8'h27;
   // row: {input, state d, state t, trans d, trans t}
   logic [9:0]      rows [10] = '{
      {2'h1, 2'h1, 2'h1, 2'h1, 2'h1}, {2'h3, 2'h3, 2'h3, 2'h3, 2'h3},
      {2'h1, 2'h0, 2'h3, 2'h3, 2'h3}, {2'h0, 2'h0, 2'h0, 2'h3, 2'h1},
      {2'h2, 2'h2, 2'h2, 2'h3, 2'h1}, {2'h0, 2'h1, 2'h1, 2'h3, 2'h1},
      {2'h1, 2'h2, 2'h2, 2'h3, 2'h1}, {2'h3, 2'h3, 2'h3, 2'h3, 2'h1},
      {2'h0, 2'h0, 2'h0, 2'h1, 2'h1}, {2'h1, 2'h1, 2'h1, 2'h0, 2'h0}};

   always #50 ref_clk = ~ref_clk;

   // ------------------------------------------
   // d-type and t-type state banks, same tables
   // ------------------------------------------
   for (genvar g = 0; g < 2; g++) begin : g_dut
      css_sequencer #(
         .SW(TB_W), .NC(TB_W), .NI(TB_W), .NO(TB_W),
         .STATE_FF(g ? css_pkg::CSS_FF_T : css_pkg::CSS_FF_D),
         .COND_MASK(TB_MASK), .COND_VAL(TB_VAL), .COND_EN(TB_EN),
         .COND_TGT(TB_TGT), .DEF_EN(TB_DEF_EN), .DEF_TGT(TB_DEF),
         .TR_EN(TB_TR_EN), .TR_VAL(TB_TR_VAL), .TR_TOGGLE(TB_TOGGLE),
         .MOORE_PAT(TB_MOORE), .MEALY_SEL(TB_MEALY)
      ) css_sequencer_inst (
         .REF_CLK(ref_clk), .RESETN(resetn), .IN_PINS(in_pins),
         .STATE(st[g]), .TRANS_OUT(tr[g]), .MEALY_REG(), .MOORE_REG(),
         .MEALY_COM(), .MOORE_COM()
      );
   end

   task automatic check(input logic [7:0] exp);
      n_checks++;
      if ({st[0], st[1], tr[0], tr[1]} !== exp) begin
         err_total++;
         $display("mismatch state_trans expected %h seen %h", exp, {st[0], st[1], tr[0], tr[1]});
      end
   endtask

   task automatic final_report();
      if (err_total == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      #100us;
      err_total++;
      final_report();
   end

   // ------------------------------------------
   // table walk, then hold and mid-run reset
   // ------------------------------------------
   initial begin
      repeat (20) @(negedge ref_clk);
      resetn = 1'b1;
      // each row takes effect three edges after it is driven
      for (int i = 0; i < 13; i++) begin
         @(negedge ref_clk);
         if (i >= 3) check(rows[i-3][7:0]);
         if (i < 10) in_pins = rows[i][9:8];
      end
      in_pins = 2'h3;
      repeat (5) @(negedge ref_clk);
      check({2'h0, 2'h3, 2'h2, 2'h2});
      resetn = 1'b0;
      @(negedge ref_clk);
      check(8'h00);
      resetn = 1'b1;
      repeat (2) @(negedge ref_clk);
      check(8'h00);
      final_report();
   end
endmodule // tb_top
